// File: pin_select_pkg.sv
package pin_select_pkg;

	localparam int ADDR_WIDTH = 12;
	localparam int DATA_WIDTH = 32;

	// byte addresses, one aligned word per register
	localparam logic [ADDR_WIDTH-1:0] ADDR_PC_DRIVE = 12'h000;
	localparam logic [ADDR_WIDTH-1:0] ADDR_AB_DRIVE = 12'h004;
	localparam logic [ADDR_WIDTH-1:0] ADDR_SUPPLY   = 12'h008;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PA_LOW   = 12'h00C;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PA_HIGH  = 12'h010;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PB_LOW   = 12'h014;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PB_HIGH  = 12'h018;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PC_LOW   = 12'h01C;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PC_HIGH  = 12'h020;
	localparam logic [ADDR_WIDTH-1:0] ADDR_INPUT    = 12'h024;

	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [3:0]  RESET_NIB   = 4'h0;
	localparam logic [1:0]  RESET_PAIR  = 2'h0;
	localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;
	localparam logic [7:0]  PAD_IDLE_BYTE = 8'hFF;

	// two-bit function codes
	localparam logic [1:0] FUNC_GPIO     = 2'h0;
	localparam logic [1:0] FUNC_ALT1     = 2'h1;
	localparam logic [1:0] FUNC_ALT2     = 2'h2;
	localparam logic [1:0] FUNC_GPIO_ALT = 2'h3;

	localparam logic [1:0] RX_FROM_PA0 = 2'h0;
	localparam logic [1:0] RX_FROM_PC3 = 2'h1;

	// field positions
	localparam int PC_DRIVE_LSB   = 2;
	localparam int PA_LO_DRIVE_LSB = 0;
	localparam int PA_HI_DRIVE_LSB = 2;
	localparam int SUPPLY_HI_LSB  = 2;
	localparam int SUPPLY_LO_LSB  = 0;
	localparam int SUPPLY_IO_BIT  = 1;
	localparam int PB7_FIELD_LSB  = 6;
	localparam int PC_DRIVE_PIN0  = 4;
	localparam int PC_RX_PIN_A    = 3;
	localparam int PC_RX_PIN_B    = 5;
	localparam int PA_LOW_GROUP   = 4;
	localparam int PA_SUPPLY_PINS = 6;

	typedef struct packed {
		logic oe;
		logic out;
	} pad_drive_type;

	localparam pad_drive_type PAD_IDLE = '{oe: 1'b0, out: 1'b0};

endpackage

// File: port_pin_function_select.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// - upper four bits of port C drive and supply registers read zero, upper six of input
// - bits 3:2 set port C 7..4 drive
// - bits 1:0 set port A 3..0 drive
// - drive level only on push-pull outputs
// - bits 3:2 choose supply for PA4, PA5
// - bits 1:0 choose supply for PA0..PA3
// - io supply needs PB7 io-supply function
// - supply select applies whatever the pin function
// - direction one is input, zero push-pull
// - PA3 codes: gpio/capture, compare, chip select
// - PA2 code 01 drives serial transmit
// - PA1 code 01 SPI out, codes 00 and 11 interrupt
// - PA0 code 01 serial receive/transmit
// - PA7 codes: capture, analog, reference input
// - PA6 codes: timer clock, amplifier, reference
// - PA5 codes: compare, serial clock, gpio
// - PA4 codes: inverted compare, serial data, gpio
// - receive source from PA0, PC3 or PC5
module port_pin_function_select
	import pin_select_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [DATA_WIDTH-1:0] pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [DATA_WIDTH-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [7:0]            paPadIn,
	output logic      [7:0]            paPadOut,
	output logic      [7:0]            paPadOe,
	input  wire logic [7:0]            paDir,
	input  wire logic [7:0]            paGpioOut,
	input  wire logic [7:0]            pcPadIn,
	input  wire logic [7:0]            pcDir,
	output logic      [15:0]           paDriveLevel,
	output logic      [7:0]            pcDriveLevel,
	output logic      [5:0]            paIoSupply,
	output logic                       ioSupplyPinSelected,
	input  wire logic                  timer1Compare,
	input  wire logic                  timer0Compare,
	input  wire logic                  timer0Inverted,
	input  wire logic                  uartTx,
	input  wire logic                  uartTxOe,
	input  wire logic                  spiDataOut,
	input  wire logic                  spiChipSelect,
	input  wire logic                  spiClkOut,
	input  wire logic                  spiClkOe,
	input  wire logic                  spiSdaOut,
	input  wire logic                  spiSdaOe,
	output logic                       timer1Capture,
	output logic                       timer0Capture,
	output logic                       timer0ExtClock,
	output logic                       extInterrupt0,
	output logic                       uartRx,
	output logic                       spiClkIn,
	output logic                       spiDataIn,
	output logic                       analogChannel0En,
	output logic                       amplifier0OutEn,
	output logic                       referenceInEn,
	output logic                       referencePinEn
);

	logic [3:0] pcDriveSel;
	logic [7:0] abDriveSel;
	logic [3:0] supplySel;
	logic [7:0] paLowSel;
	logic [7:0] paHighSel;
	logic [7:0] pbLowSel;
	logic [7:0] pbHighSel;
	logic [7:0] pcLowSel;
	logic [7:0] pcHighSel;
	logic [1:0] rxPinSel;

	// bus decode
	wire accessPhase = psel & penable;
	wire setupPhase  = psel & ~penable;
	wire hitPcDrive  = (paddr == ADDR_PC_DRIVE);
	wire hitAbDrive  = (paddr == ADDR_AB_DRIVE);
	wire hitSupply   = (paddr == ADDR_SUPPLY);
	wire hitPaLow    = (paddr == ADDR_PA_LOW);
	wire hitPaHigh   = (paddr == ADDR_PA_HIGH);
	wire hitPbLow    = (paddr == ADDR_PB_LOW);
	wire hitPbHigh   = (paddr == ADDR_PB_HIGH);
	wire hitPcLow    = (paddr == ADDR_PC_LOW);
	wire hitPcHigh   = (paddr == ADDR_PC_HIGH);
	wire hitInput    = (paddr == ADDR_INPUT);
	wire mapped      = hitPcDrive | hitAbDrive | hitSupply | hitPaLow | hitPaHigh
	                 | hitPbLow | hitPbHigh | hitPcLow | hitPcHigh | hitInput;
	// only the low byte lane holds register bits
	wire writeByte   = accessPhase & pwrite & mapped & pstrb[0];

	assign pready  = 1'b1;
	assign pslverr = accessPhase & ~mapped;

	wire [7:0] readByte =
		hitPcDrive ? {4'h0, pcDriveSel} :
		hitAbDrive ? abDriveSel :
		hitSupply  ? {4'h0, supplySel} :
		hitPaLow   ? paLowSel :
		hitPaHigh  ? paHighSel :
		hitPbLow   ? pbLowSel :
		hitPbHigh  ? pbHighSel :
		hitPcLow   ? pcLowSel :
		hitPcHigh  ? pcHighSel :
		hitInput   ? {6'h00, rxPinSel} : RESET_BYTE;

	// read data settles in setup so the access phase needs no wait
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata <= READ_ZERO;
		end else if (setupPhase) begin
			prdata <= {24'h00_0000, readByte};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pcDriveSel <= RESET_NIB;
			abDriveSel <= RESET_BYTE;
			supplySel  <= RESET_NIB;
			paLowSel   <= RESET_BYTE;
			paHighSel  <= RESET_BYTE;
			pbLowSel   <= RESET_BYTE;
			pbHighSel  <= RESET_BYTE;
			pcLowSel   <= RESET_BYTE;
			pcHighSel  <= RESET_BYTE;
			rxPinSel   <= RESET_PAIR;
		end else if (writeByte) begin
			if (hitPcDrive) pcDriveSel <= pwdata[3:0];
			if (hitAbDrive) abDriveSel <= pwdata[7:0];
			if (hitSupply)  supplySel  <= pwdata[3:0];
			if (hitPaLow)   paLowSel   <= pwdata[7:0];
			if (hitPaHigh)  paHighSel  <= pwdata[7:0];
			if (hitPbLow)   pbLowSel   <= pwdata[7:0];
			if (hitPbHigh)  pbHighSel  <= pwdata[7:0];
			if (hitPcLow)   pcLowSel   <= pwdata[7:0];
			if (hitPcHigh)  pcHighSel  <= pwdata[7:0];
			if (hitInput)   rxPinSel   <= pwdata[1:0];
		end
	end

	// three-stage sync, reset high: no false start bit on receive
	logic [7:0] paSync1, paSync2, paSync3, paIn;
	logic [7:0] pcSync1, pcSync2, pcSync3, pcIn;
	wire  [7:0] paDiffer = paSync2 ^ paSync3;
	wire  [7:0] pcDiffer = pcSync2 ^ pcSync3;
	wire  [7:0] next_paIn = (~paDiffer & paSync3) | (paDiffer & paIn);
	wire  [7:0] next_pcIn = (~pcDiffer & pcSync3) | (pcDiffer & pcIn);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			paSync1 <= PAD_IDLE_BYTE;
			paSync2 <= PAD_IDLE_BYTE;
			paSync3 <= PAD_IDLE_BYTE;
			paIn    <= PAD_IDLE_BYTE;
			pcSync1 <= PAD_IDLE_BYTE;
			pcSync2 <= PAD_IDLE_BYTE;
			pcSync3 <= PAD_IDLE_BYTE;
			pcIn    <= PAD_IDLE_BYTE;
		end else begin
			paSync1 <= paPadIn;
			paSync2 <= paSync1;
			paSync3 <= paSync2;
			paIn    <= next_paIn;
			pcSync1 <= pcPadIn;
			pcSync2 <= pcSync1;
			pcSync3 <= pcSync2;
			pcIn    <= next_pcIn;
		end
	end

	function automatic pad_drive_type select_drive(
		input logic [1:0]    code,
		input pad_drive_type gpio,
		input pad_drive_type alt1,
		input pad_drive_type alt2
	);
		pad_drive_type result;
		result = gpio;
		unique case (code)
			FUNC_GPIO:     result = gpio;
			FUNC_ALT1:     result = alt1;
			FUNC_ALT2:     result = alt2;
			FUNC_GPIO_ALT: result = gpio;
		endcase
		return result;
	endfunction

	wire [15:0] paCodes = {paHighSel, paLowSel};

	pad_drive_type gpioDrv [8];
	pad_drive_type alt1Drv [8];
	pad_drive_type alt2Drv [8];
	pad_drive_type padDrv  [8];
	logic [7:0]    isGpio;

	assign alt1Drv[3] = '{oe: 1'b1, out: timer1Compare};
	assign alt2Drv[3] = '{oe: 1'b1, out: spiChipSelect};
	assign alt1Drv[2] = '{oe: 1'b1, out: uartTx};
	assign alt2Drv[2] = gpioDrv[2];
	assign alt1Drv[1] = '{oe: 1'b1, out: spiDataOut};
	assign alt2Drv[1] = gpioDrv[1];
	assign alt1Drv[0] = '{oe: uartTxOe, out: uartTx};
	assign alt2Drv[0] = gpioDrv[0];
	assign alt1Drv[7] = PAD_IDLE;
	assign alt2Drv[7] = PAD_IDLE;
	assign alt1Drv[6] = PAD_IDLE;
	assign alt2Drv[6] = PAD_IDLE;
	assign alt1Drv[5] = '{oe: 1'b1, out: timer0Compare};
	assign alt2Drv[5] = '{oe: spiClkOe, out: spiClkOut};
	assign alt1Drv[4] = '{oe: 1'b1, out: timer0Inverted};
	assign alt2Drv[4] = '{oe: spiSdaOe, out: spiSdaOut};

	genvar pin;
	generate
		for (pin = 0; pin < 8; pin++) begin : g_pad
			assign gpioDrv[pin] = '{oe: ~paDir[pin], out: paGpioOut[pin]};
			assign isGpio[pin]  = (paCodes[2*pin +: 2] == FUNC_GPIO)
			                    | (paCodes[2*pin +: 2] == FUNC_GPIO_ALT);
			assign padDrv[pin]  = select_drive(paCodes[2*pin +: 2], gpioDrv[pin],
			                                   alt1Drv[pin], alt2Drv[pin]);
		end
	endgenerate

	logic [7:0] next_padOut;
	logic [7:0] next_padOe;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_padOut[i] = padDrv[i].out;
			next_padOe[i]  = padDrv[i].oe;
		end
	end

	logic [15:0] next_paLevel;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!next_padOe[i]) begin
				next_paLevel[2*i +: 2] = RESET_PAIR;
			end else if (i < PA_LOW_GROUP) begin
				next_paLevel[2*i +: 2] = abDriveSel[PA_LO_DRIVE_LSB +: 2];
			end else begin
				next_paLevel[2*i +: 2] = abDriveSel[PA_HI_DRIVE_LSB +: 2];
			end
		end
	end

	logic [7:0] next_pcLevel;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			next_pcLevel[2*i +: 2] = pcDir[PC_DRIVE_PIN0 + i] ? RESET_PAIR
			                       : pcDriveSel[PC_DRIVE_LSB +: 2];
		end
	end

	// io supply pin function on PB7
	wire pb7IoSupply = (pbHighSel[PB7_FIELD_LSB +: 2] == FUNC_ALT1);
	wire supplyHiIo  = supplySel[SUPPLY_HI_LSB + SUPPLY_IO_BIT] & pb7IoSupply;
	wire supplyLoIo  = supplySel[SUPPLY_LO_LSB + SUPPLY_IO_BIT] & pb7IoSupply;
	wire [5:0] next_ioSupply = {{2{supplyHiIo}}, {4{supplyLoIo}}};

	// capture, timer clock and interrupt inputs only with direction input
	wire gpioIn3 = isGpio[3] & paDir[3];
	wire gpioIn1 = isGpio[1] & paDir[1];
	wire gpioIn7 = isGpio[7] & paDir[7];
	wire gpioIn6 = isGpio[6] & paDir[6];
	wire next_rx = (rxPinSel == RX_FROM_PA0) ? paIn[0] :
	               (rxPinSel == RX_FROM_PC3) ? pcIn[PC_RX_PIN_A] : pcIn[PC_RX_PIN_B];
	// serial clock and data idle high when not routed, like an open bus
	wire next_spiClk  = (paCodes[11:10] == FUNC_ALT2) ? paIn[5] : 1'b1;
	wire next_spiData = (paCodes[9:8] == FUNC_ALT2) ? paIn[4] : 1'b1;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			paPadOut <= RESET_BYTE;
			paPadOe  <= RESET_BYTE;
			paDriveLevel <= 16'h0000;
			pcDriveLevel <= RESET_BYTE;
			paIoSupply   <= 6'h00;
			ioSupplyPinSelected <= 1'b0;
		end else begin
			paPadOut <= next_padOut;
			paPadOe  <= next_padOe;
			paDriveLevel <= next_paLevel;
			pcDriveLevel <= next_pcLevel;
			paIoSupply   <= next_ioSupply;
			ioSupplyPinSelected <= pb7IoSupply;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timer1Capture    <= 1'b0;
			extInterrupt0    <= 1'b0;
			timer0Capture    <= 1'b0;
			timer0ExtClock   <= 1'b0;
			uartRx           <= 1'b1;
			spiClkIn         <= 1'b1;
			spiDataIn        <= 1'b1;
			analogChannel0En <= 1'b0;
			amplifier0OutEn  <= 1'b0;
			referenceInEn    <= 1'b0;
			referencePinEn   <= 1'b0;
		end else begin
			timer1Capture    <= gpioIn3 & paIn[3];
			extInterrupt0    <= gpioIn1 & paIn[1];
			timer0Capture    <= gpioIn7 & paIn[7];
			timer0ExtClock   <= gpioIn6 & paIn[6];
			uartRx           <= next_rx;
			spiClkIn         <= next_spiClk;
			spiDataIn        <= next_spiData;
			analogChannel0En <= (paCodes[15:14] == FUNC_ALT1);
			amplifier0OutEn  <= (paCodes[13:12] == FUNC_ALT1);
			referenceInEn    <= (paCodes[15:14] == FUNC_ALT2);
			referencePinEn   <= (paCodes[13:12] == FUNC_ALT2);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_write_pa_low;
		accessPhase && pwrite && hitPaLow && pstrb[0];
	endsequence
	sequence s_read_drive_c;
		setupPhase && !pwrite && hitPcDrive ##1 accessPhase;
	endsequence
	property p_reserved_zero;
		s_read_drive_c |-> prdata[31:4] == 28'h000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
	property p_pc_drive;
		(!pcDir[7] && pcDriveSel[3:2] == 2'h3) |=> pcDriveLevel[7:6] == 2'h3;
	endproperty
	a_pc_drive: assert property (p_pc_drive) else $error("port C drive level wrong");
	property p_pa_drive;
		(next_padOe[0] && abDriveSel[1:0] == 2'h3) |=> paDriveLevel[1:0] == 2'h3;
	endproperty
	a_pa_drive: assert property (p_pa_drive) else $error("port A drive level wrong");
	property p_input_no_level;
		!next_padOe[2] |=> paDriveLevel[5:4] == 2'h0;
	endproperty
	a_input_no_level: assert property (p_input_no_level) else $error("level on non-output");
	property p_supply_needs_pb7;
		(pbHighSel[7:6] != 2'h1) |=> paIoSupply == 6'h00;
	endproperty
	a_supply_needs_pb7: assert property (p_supply_needs_pb7) else $error("io supply without pin");
	property p_supply_hi;
		(supplySel[3] && pbHighSel[7:6] == 2'h1) |=> paIoSupply[5:4] == 2'h3;
	endproperty
	a_supply_hi: assert property (p_supply_hi) else $error("upper supply not io");
	property p_tx_route;
		(paLowSel[5:4] == 2'h1) |=> paPadOe[2] && paPadOut[2] == $past(uartTx);
	endproperty
	a_tx_route: assert property (p_tx_route) else $error("transmit not on pin");
	property p_sdo_route;
		(paLowSel[3:2] == 2'h1) |=> paPadOut[1] == $past(spiDataOut);
	endproperty
	a_sdo_route: assert property (p_sdo_route) else $error("SPI data not on pin");
	property p_analog_float;
		(paHighSel[7:6] == 2'h1) |=> !paPadOe[7] ##0 analogChannel0En;
	endproperty
	a_analog_float: assert property (p_analog_float) else $error("analog pin driven");
	property p_write_to_pad;
		s_write_pa_low ##1 (paLowSel[5:4] == 2'h1) |=> paPadOut[2] == $past(uartTx);
	endproperty
	a_write_to_pad: assert property (p_write_to_pad) else $error("write not applied");
	property p_rx_pc3;
		(rxPinSel == 2'h1) |=> uartRx == $past(pcIn[3]);
	endproperty
	a_rx_pc3: assert property (p_rx_pc3) else $error("receive source wrong");

endmodule

// File: pin_partner_model.sv
`timescale 1ns/100ps
module pin_partner_model
	import pin_select_pkg::*;
(
	input  wire logic [7:0]  paPadOut,
	input  wire logic [7:0]  paPadOe,
	input  wire logic [7:0]  paExt,
	input  wire logic [7:0]  pcExt,
	input  wire logic        perOn,
	input  wire logic        perLevel,
	output logic      [7:0]  paPadIn,
	output logic      [7:0]  pcPadIn,
	output logic      [10:0] perOut
);
	// device wins the wire while driving
	assign paPadIn = (paPadOe & paPadOut) | (~paPadOe & paExt);
	assign pcPadIn = pcExt;
	// idle while disabled
	// enables follow perOn alone, so a low data level still drives the pad
	assign perOut = perOn ? ({11{perLevel}} | 11'h045) : 11'h000;
endmodule

// File: port_pin_function_select_bench.sv
`timescale 1ns/100ps
module port_pin_function_select_bench;
	import pin_select_pkg::*;
	logic                  refClk;
	logic                  rstN;
	logic                  psel, penable, pwrite, pready, pslverr;
	logic [ADDR_WIDTH-1:0] paddr;
	logic [DATA_WIDTH-1:0] pwdata, prdata;
	logic [3:0]            pstrb;
	logic [7:0]            paPadIn, paPadOut, paPadOe, paDir, paGpioOut;
	logic [7:0]            pcPadIn, pcDir, paExt, pcExt;
	logic [15:0]           paDriveLevel;
	logic [7:0]            pcDriveLevel;
	logic [5:0]            paIoSupply;
	logic                  ioSupplyPinSelected, perOn, perLevel;
	logic                  timer1Compare, timer0Compare, timer0Inverted, uartTx, uartTxOe, spiDataOut;
	logic                  spiChipSelect, spiClkOut, spiClkOe, spiSdaOut, spiSdaOe;
	logic                  timer1Capture, timer0Capture, timer0ExtClock, extInterrupt0, uartRx;
	logic                  spiClkIn, spiDataIn, analogChannel0En, amplifier0OutEn, referenceInEn, referencePinEn;
	logic [10:0]           perOut;
	int                    num_errors = 0;
	int                    comparisons = 0;
	int                    cycles = 0;
	logic [7:0]            wrExp [10] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03};
	logic [7:0]            fnSel [4] = '{8'h55, 8'hAA, 8'hFF, 8'h00};
	logic [7:0]            fnOe [4] = '{8'h3F, 8'h38, 8'h00, 8'h00};
	logic [3:0]            fnEn [4] = '{4'hC, 4'h3, 4'h0, 4'h0};

	assign {timer1Compare, timer0Compare, timer0Inverted, uartTx, uartTxOe, spiDataOut,
		spiChipSelect, spiClkOut, spiClkOe, spiSdaOut, spiSdaOe} = perOut;

	port_pin_function_select port_pin_function_select_i (.ref_clk(refClk), .rst_n(rstN), .*);

	pin_partner_model pin_partner_model_i (
		.paPadOut(paPadOut),
		.paPadOe (paPadOe),
		.paExt   (paExt),
		.pcExt   (pcExt),
		.perOn   (perOn),
		.perLevel(perLevel),
		.paPadIn (paPadIn),
		.pcPadIn (pcPadIn),
		.perOut  (perOut)
	);

	initial begin
		refClk = 1'b0;
		forever #2 refClk = ~refClk;
	end

	task automatic stop_test;
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// generous ceiling: the sequence needs under two thousand cycles
	always @(posedge refClk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge refClk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge refClk);
		penable <= 1'b1;
		// only the bench timeout ends a stalled access
		do begin
			@(posedge refClk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [ADDR_WIDTH-1:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge refClk);
	endtask

	initial begin
		int          i;
		int          lv;
		logic [31:0] d;
		logic        e;
		rstN = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		paDir = 8'hFF;
		paGpioOut = 8'h00;
		pcDir = 8'hFF;
		paExt = 8'hFF;
		pcExt = 8'hFF;
		perOn = 1'b0;
		perLevel = 1'b0;
		repeat (16) @(posedge refClk);
		rstN <= 1'b1;
		for (i = 0; i < 10; i++) begin
			rd(12'(4 * i), d);
			check("reset value", d, READ_ZERO);
			wr(12'(4 * i), 32'hFFFF_FFFF);
			rd(12'(4 * i), d);
			check("readback", d, 32'(wrExp[i]));
			wr(12'(4 * i), 32'h0000_0000);
		end
		apb(1'b1, 12'h028, 32'h0000_00FF, d, e);
		check("unmapped write error", 32'(e), 32'h0000_0001);
		apb(1'b0, 12'h028, 32'h0000_0000, d, e);
		check("unmapped read data", d, READ_ZERO);
		pstrb <= 4'hE;
		wr(ADDR_PA_LOW, 32'h0000_0055);
		pstrb <= 4'hF;
		rd(ADDR_PA_LOW, d);
		check("masked write", d, READ_ZERO);
		// drive strength only on push-pull pins
		paDir <= 8'hF0;
		paGpioOut <= 8'hA5;
		wr(ADDR_AB_DRIVE, 32'h0000_000B);
		settle(2);
		check("pa drive low", 32'(paDriveLevel), 32'h0000_00FF);
		check("pad oe", 32'(paPadOe), 32'h0000_000F);
		check("pad out", 32'(paPadOut & paPadOe), 32'h0000_0005);
		paDir <= 8'h0F;
		settle(2);
		check("pa drive high", 32'(paDriveLevel), 32'h0000_AA00);
		pcDir <= 8'h30;
		for (i = 0; i < 4; i++) begin
			wr(ADDR_PC_DRIVE, 32'(i * 4));
			settle(2);
			check("pc drive", 32'(pcDriveLevel), 32'({2'(i), 2'(i), 4'h0}));
		end
		wr(ADDR_AB_DRIVE, 32'h0000_0000);
		paDir <= 8'hFF;
		paGpioOut <= 8'h00;
		// function table, peripheral enabled only after selection
		for (i = 0; i < 4; i++) begin
			wr(ADDR_PA_LOW, 32'(fnSel[i]));
			wr(ADDR_PA_HIGH, 32'(fnSel[i]));
			for (lv = 0; lv < 2; lv++) begin
				perLevel <= lv[0];
				perOn <= 1'b1;
				settle(3);
				check("fn oe", 32'(paPadOe & 8'h3F), 32'(fnOe[i]));
				check("fn out", 32'(paPadOut & fnOe[i]), 32'(fnOe[i] & {8{lv[0]}}));
				check("analog en", 32'({analogChannel0En, amplifier0OutEn, referenceInEn, referencePinEn}),
					32'(fnEn[i]));
				perOn <= 1'b0;
				settle(1);
			end
		end
		// io supply needs the port B pin as well
		wr(ADDR_SUPPLY, 32'h0000_000A);
		settle(2);
		check("supply without pin", 32'({ioSupplyPinSelected, paIoSupply}), 32'h0000_0000);
		wr(ADDR_PB_HIGH, 32'h0000_0040);
		settle(2);
		check("supply all io", 32'({ioSupplyPinSelected, paIoSupply}), 32'h0000_007F);
		wr(ADDR_SUPPLY, 32'h0000_0006);
		settle(2);
		check("supply low io", 32'({ioSupplyPinSelected, paIoSupply}), 32'h0000_004F);
		wr(ADDR_SUPPLY, 32'h0000_0009);
		settle(2);
		check("supply high io", 32'({ioSupplyPinSelected, paIoSupply}), 32'h0000_0070);
		for (i = 0; i < 4; i++) begin
			wr(ADDR_INPUT, 32'(i));
			paExt <= (i == 0) ? 8'hFE : 8'hFF;
			pcExt <= (i == 1) ? 8'hF7 : ((i > 1) ? 8'hDF : 8'hFF);
			settle(8);
			check("receive source", 32'(uartRx), 32'h0000_0000);
		end
		pcExt <= 8'hFF;
		// capture, timer clock and interrupt inputs need direction set to input
		for (lv = 0; lv < 2; lv++) begin
			paExt <= {8{lv[0]}};
			settle(8);
			check("capture inputs", 32'({timer1Capture, extInterrupt0, timer0Capture, timer0ExtClock}),
				32'({4{lv[0]}}));
		end
		paDir <= 8'h00;
		paGpioOut <= 8'hFF;
		settle(8);
		check("capture gated", 32'({timer1Capture, extInterrupt0, timer0Capture, timer0ExtClock}),
			32'h0000_0000);
		paDir <= 8'hFF;
		paGpioOut <= 8'h00;
		paExt <= 8'h00;
		wr(ADDR_PA_HIGH, 32'h0000_000A);
		settle(8);
		check("serial inputs", 32'({spiClkIn, spiDataIn}), 32'h0000_0000);
		wr(ADDR_PA_HIGH, 32'h0000_0000);
		settle(3);
		check("serial idle", 32'({spiClkIn, spiDataIn}), 32'h0000_0003);
		stop_test();
	end
endmodule
